// File: hw/switch_ctrl_defs.svh
// Constants of the isolated switch enable control.
`ifndef SWITCH_CTRL_DEFS_SVH
`define SWITCH_CTRL_DEFS_SVH
`define CLK_PERIOD_NS       10
`define ONESHOT_WIDTH_NS    1000
`define ONESHOT_CYCLES      ((`ONESHOT_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRIMARY_TIMEOUT_US  100
`define PRIMARY_TIMEOUT_CYC ((`PRIMARY_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define MODE_SETTLE_CYCLES  4
`endif

// File: hw/switch_ctrl_pkg.sv
// Types shared by the isolated switch enable control.
`default_nettype none
package switch_ctrl_pkg;
	typedef enum logic [3:0] {
		ST_OFF    = 4'b0001,
		ST_ARMED  = 4'b0010,
		ST_PULSE  = 4'b0100,
		ST_WAITLO = 4'b1000
	} shot_state_e;

	typedef struct packed {
		logic primary_supply;
		logic secondary_high_rail;
		logic secondary_mid_rail;
		logic over_temp;
	} supply_status_s;
endpackage : switch_ctrl_pkg
`default_nettype wire

// File: hw/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_srst,
	input  wire logic [WIDTH-1:0] i_async,
	output var  logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : sync2
`default_nettype wire

// File: hw/isolated_switch_enable_control.sv
// Gate drive decision logic from enable input and supply health.
`include "switch_ctrl_defs.svh"
`default_nettype none
module isolated_switch_enable_control
	import switch_ctrl_pkg::*;
#(
	parameter bit          ONESHOT_VARIANT = 1'b0,
	parameter int unsigned PULSE_CYCLES    = `ONESHOT_CYCLES,
	parameter int unsigned TIMEOUT_CYCLES  = `PRIMARY_TIMEOUT_CYC
) (
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	input  wire logic i_enable,
	input  wire logic i_primary_supply,
	input  wire logic i_secondary_high_rail,
	input  wire logic i_secondary_mid_rail,
	input  wire logic i_over_temp,
	output var  logic o_gate_drive_output,
	output var  logic o_keep_off,
	output var  logic o_power_transfer,
	output var  logic o_three_wire_mode
);
	localparam int unsigned SETTLE     = `MODE_SETTLE_CYCLES;
	localparam int unsigned PULSE_MAX  = 32'h0000_ffff;
	localparam int unsigned SETTLE_MAX = 32'h0000_0008;

	// The pulse counter is sixteen bits and the settle counter three bits wide;
	// a count beyond either would wrap the compare value and end the pulse or the capture early.
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > PULSE_MAX) begin : g_bad_pulse
		$error("isolated_switch_enable_control: pulse count out of range");
	end
	// A zero timeout would wrap the compare value and wait the whole counter range.
	if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
		$error("isolated_switch_enable_control: timeout count out of range");
	end
	if (SETTLE < 1 || SETTLE > SETTLE_MAX) begin : g_bad_settle
		$error("isolated_switch_enable_control: settle count out of range");
	end

	supply_status_s raw_s;
	supply_status_s sup_s;
	logic           en_s;

	assign raw_s = '{primary_supply: i_primary_supply, secondary_high_rail: i_secondary_high_rail,
		secondary_mid_rail: i_secondary_mid_rail, over_temp: i_over_temp};

	// All five levels share one synchroniser, so each reaches the logic after
	// the same two cycles.
	sync2 #(.WIDTH(5)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_async   ({raw_s, i_enable}),
		.o_sync    ({sup_s, en_s})
	);

	// The wire mode is taken once the synchronised primary supply has stood
	// for the settle count. Enable already high then means the host feeds the
	// device through enable, which is two-wire mode. The choice holds until the
	// primary supply drops, because a mode change under power would glitch the
	// gate drive output.
	logic        mode_valid_reg;
	logic        three_wire_reg;
	logic [2:0]  settle_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mode_valid_reg <= 1'b0;
			three_wire_reg <= 1'b0;
			settle_reg     <= '0;
		end else begin
			if (!sup_s.primary_supply) begin
				mode_valid_reg <= 1'b0;
				settle_reg     <= '0;
			end else if (!mode_valid_reg) begin
				if (settle_reg == 3'(SETTLE - 1)) begin
					mode_valid_reg <= 1'b1;
					// enable low when the settle count ends means a separate primary supply.
					three_wire_reg <= !en_s;
				end else begin
					settle_reg <= settle_reg + 3'h1;
				end
			end
		end
	end

	// Primary-loss timeout. The counter stops once expired, so it cannot wrap
	// round and let a held gate drive output come back on.
	logic [31:0] to_cnt_reg;
	logic        to_expired_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			to_cnt_reg     <= '0;
			to_expired_reg <= 1'b0;
		end else if (sup_s.primary_supply) begin
			to_cnt_reg     <= '0;
			to_expired_reg <= 1'b0;
		end else if (!to_expired_reg) begin
			if (to_cnt_reg == TIMEOUT_CYCLES - 1)
				to_expired_reg <= 1'b1;
			else
				to_cnt_reg <= to_cnt_reg + 32'h1;
		end
	end

	// Until the timeout runs out the output keeps its last commanded level,
	// since the primary side can no longer signal it low.
	logic rails_ok;
	logic run_ok;
	// Either secondary rail low forces the gate low ahead of every other term.
	// rail checks
	assign rails_ok = sup_s.secondary_high_rail && sup_s.secondary_mid_rail;
	// Over-temperature only forces the gate low while the primary side is up;
	// with the primary side gone the timeout path decides instead.
	// thermal force low
	assign run_ok = rails_ok && sup_s.primary_supply && mode_valid_reg && !sup_s.over_temp;

	logic use_oneshot;
	assign use_oneshot = ONESHOT_VARIANT && three_wire_reg;

	// One-shot sequencer. A pulse starts only from ST_ARMED, reached by seeing
	// enable low; any fault drops back to ST_WAITLO, so a host that holds enable
	// high across a fault cannot fire a stray pulse afterwards.
	shot_state_e state_reg;
	logic [15:0] pulse_cnt_reg;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state_reg     <= ST_WAITLO;
			pulse_cnt_reg <= '0;
		end else if (!run_ok || !use_oneshot) begin
			state_reg     <= ST_WAITLO;
			pulse_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_OFF, ST_WAITLO: begin
					if (!en_s)
						state_reg <= ST_ARMED;
				end
				ST_ARMED: begin
					if (en_s) begin
						state_reg     <= ST_PULSE;
						pulse_cnt_reg <= '0;
					end
				end
				ST_PULSE: begin
					if (pulse_cnt_reg == 16'(PULSE_CYCLES - 1))
						state_reg <= ST_WAITLO;
					else
						pulse_cnt_reg <= pulse_cnt_reg + 16'h1;
				end
				default: state_reg <= ST_WAITLO;
			endcase
		end
	end

	logic drive_next;
	always_comb begin
		drive_next = 1'b0;
		if (!rails_ok)
			drive_next = 1'b0;
		else if (!sup_s.primary_supply)
			drive_next = o_gate_drive_output && !to_expired_reg;
		else if (!run_ok)
			drive_next = 1'b0;
		// The pulse starts from the armed state in the cycle of the synchronised
		// edge, one cycle sooner than waiting for ST_PULSE.
		else if (use_oneshot)
			drive_next = (state_reg == ST_ARMED && en_s) || state_reg == ST_PULSE;
		else
			drive_next = en_s;
	end

	// Keep-off is the exact complement of the drive, so the two never overlap.
	// keep-off path
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_gate_drive_output <= 1'b0;
			o_keep_off          <= 1'b1;
		end else begin
			o_gate_drive_output <= drive_next;
			o_keep_off          <= !drive_next;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_power_transfer <= 1'b0;
		end else begin
			o_power_transfer <= sup_s.primary_supply && !sup_s.over_temp;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_three_wire_mode <= 1'b0;
		end else begin
			o_three_wire_mode <= three_wire_reg;
		end
	end
endmodule : isolated_switch_enable_control
`default_nettype wire

// File: verif/host_model.sv
// Host controller model that drives the enable line.
`default_nettype none
module host_model (
	input  wire logic i_sys_clk,
	input  wire logic i_cmd,
	output var  logic o_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cmd_seen = 1'b0;
	logic level    = 1'b0;
	always @(posedge i_sys_clk) cmd_seen <= i_cmd;
	always @(negedge i_sys_clk) level <= cmd_seen;
	assign o_enable = level;
endmodule : host_model
`default_nettype wire

// File: verif/isolated_switch_enable_control_chk.sv
// Port checker for the switch enable control.
`default_nettype none
module isolated_switch_enable_control_chk #(
	parameter bit          ONESHOT_VARIANT = 1'b1,
	parameter int unsigned PULSE_CYCLES   = 4,
	parameter int unsigned TIMEOUT_CYCLES = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_enable,
	input wire logic i_primary_supply,
	input wire logic i_secondary_high_rail,
	input wire logic i_secondary_mid_rail,
	input wire logic i_over_temp,
	input wire logic o_gate_drive_output,
	input wire logic o_keep_off,
	input wire logic o_power_transfer,
	input wire logic o_three_wire_mode
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic        ok;
	int unsigned ok_cnt, hi_cnt, pd_cnt, lo_cnt;
	assign ok = i_primary_supply && i_secondary_high_rail && i_secondary_mid_rail && !i_over_temp;
	always_ff @(posedge i_sys_clk) begin
		ok_cnt <= (i_srst || !ok) ? 0 : ok_cnt + 1;
		hi_cnt <= (i_srst || !o_gate_drive_output) ? 0 : hi_cnt + 1;
		pd_cnt <= (i_srst || i_primary_supply || !i_secondary_high_rail) ? 0 : pd_cnt + 1;
		lo_cnt <= (i_srst || i_enable) ? 0 : lo_cnt + 1;
	end
	sequence s_hi_down; (!i_secondary_high_rail)[*3]; endsequence
	sequence s_shot_end; $fell(o_gate_drive_output) && ONESHOT_VARIANT && o_three_wire_mode && ok_cnt > 8; endsequence
	AST_HI_DOWN: assert property (s_hi_down |=> !o_gate_drive_output && o_keep_off)
		else $error("gate on with high rail down");
	AST_MID_DOWN: assert property ((!i_secondary_mid_rail)[*3] |=> !o_gate_drive_output)
		else $error("gate on with mid rail down");
	AST_HOT: assert property ((i_over_temp && i_primary_supply)[*3] |=> !o_gate_drive_output && !o_power_transfer)
		else $error("gate or transfer on while hot");
	AST_FOLLOW: assert property (ok_cnt > 12 && !(ONESHOT_VARIANT && o_three_wire_mode)
		|-> o_gate_drive_output == $past(i_enable, 3))
		else $error("gate not following enable");
	AST_WIDTH: assert property (s_shot_end |-> hi_cnt == PULSE_CYCLES + 1)
		else $error("pulse width wrong");
	AST_NO_REARM: assert property ((o_three_wire_mode && i_enable)[*8] |-> !$rose(o_gate_drive_output))
		else $error("pulse without enable low");
	AST_SHOT_LOW: assert property (o_three_wire_mode && lo_cnt > PULSE_CYCLES + 4 |-> !o_gate_drive_output)
		else $error("gate on with enable low");
	AST_TIMEOUT: assert property (pd_cnt > TIMEOUT_CYCLES + 4 |-> !o_gate_drive_output)
		else $error("gate on after primary timeout");
endmodule : isolated_switch_enable_control_chk
bind isolated_switch_enable_control isolated_switch_enable_control_chk #(.ONESHOT_VARIANT(ONESHOT_VARIANT),
	.PULSE_CYCLES(PULSE_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES))
	u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_enable(i_enable),
	.i_primary_supply(i_primary_supply), .i_secondary_high_rail(i_secondary_high_rail),
	.i_secondary_mid_rail(i_secondary_mid_rail), .i_over_temp(i_over_temp),
	.o_gate_drive_output(o_gate_drive_output), .o_keep_off(o_keep_off),
	.o_power_transfer(o_power_transfer), .o_three_wire_mode(o_three_wire_mode));
`default_nettype wire

// File: verif/isolated_switch_enable_control_bench.sv
// Bench for the switch enable control, one-shot and standard variants side by side.
`default_nettype none
module isolated_switch_enable_control_bench;
	import switch_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, srst = 1, cmd = 0, pri = 0, hi = 1, mid = 1, hot = 0;
	logic en, gate, koff, ptx, tw, gate_std, tw_std;
	int   mismatches = 0, checks = 0;
	host_model u_host (.i_sys_clk(clk), .i_cmd(cmd), .o_enable(en));
	isolated_switch_enable_control #(.ONESHOT_VARIANT(1'b1), .PULSE_CYCLES(4), .TIMEOUT_CYCLES(20)) u_dut (
		.i_sys_clk(clk), .i_srst(srst), .i_enable(en), .i_primary_supply(pri), .i_secondary_high_rail(hi),
		.i_secondary_mid_rail(mid), .i_over_temp(hot), .o_gate_drive_output(gate), .o_keep_off(koff),
		.o_power_transfer(ptx), .o_three_wire_mode(tw));
	isolated_switch_enable_control #(.ONESHOT_VARIANT(1'b0), .PULSE_CYCLES(4), .TIMEOUT_CYCLES(20)) u_dut_std (
		.i_sys_clk(clk), .i_srst(srst), .i_enable(en), .i_primary_supply(pri), .i_secondary_high_rail(hi),
		.i_secondary_mid_rail(mid), .i_over_temp(hot), .o_gate_drive_output(gate_std), .o_keep_off(),
		.o_power_transfer(), .o_three_wire_mode(tw_std));
	task chk(string n, logic s, logic e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", n, e, s);
		end
	endtask : chk
	task step(int n);
		repeat (n) @(negedge clk);
	endtask : step
	// Enable level at primary rise picks the wire mode.
	task pwr(logic e);
		pri = 0;
		cmd = e;
		step(4);
		pri = 1;
		step(12);
	endtask : pwr
	task t_shot;
		pwr(0);
		chk("mode", tw, 1);
		chk("std mode", tw_std, 1);
		cmd = 1; step(5); chk("gate", gate, 1);
		chk("std gate", gate_std, 1);
		step(6); chk("gate", gate, 0);
		chk("std gate", gate_std, 1);
		cmd = 0; step(5); chk("gate", gate, 0);
		chk("std gate", gate_std, 0);
		cmd = 1; step(5); chk("gate", gate, 1);
		step(6); cmd = 0;
		step(5); chk("gate", gate, 0);
		chk("std gate", gate_std, 0);
	endtask : t_shot
	task t_two;
		pwr(1);
		chk("mode", tw, 0);
		chk("std mode", tw_std, 0);
		chk("gate", gate, 1);
		hi = 0; step(5); chk("gate", gate, 0); chk("koff", koff, 1);
		hi = 1; mid = 0; step(5); chk("gate", gate, 0);
		mid = 1; hot = 1; step(5); chk("gate", gate, 0); chk("ptx", ptx, 0);
		hot = 0; step(5); chk("ptx", ptx, 1);
		cmd = 0; step(5); chk("gate", gate, 0);
		cmd = 1; step(5); chk("gate", gate, 1);
		pri = 0; step(5); chk("gate", gate, 1);
		step(25); chk("gate", gate, 0);
	endtask : t_two
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial forever #5 clk = ~clk;
	// The whole run is about 126 cycles.
	initial begin
		step(2000);
		mismatches++;
		wrap_up();
	end
	initial begin
		step(2);
		srst = 0;
		t_shot();
		t_two();
		wrap_up();
	end
endmodule : isolated_switch_enable_control_bench
`default_nettype wire
